// ---- rtl/mtm_edge_sync.sv ----
// Purpose: Synchronises the external timer clock pin and detects edges.
// Assumes: Pin toggles at no more than a quarter of the bus clock.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ps
`default_nettype none
module mtm_edge_sync (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic pin_i,
    output logic      rise_o,
    output logic      fall_o
);
    logic meta_r;
    logic sync_r;
    logic prev_r;
    logic rise_nxt;
    logic fall_nxt;

    // Edges are judged only from the second and third stages, never the first.
    always_comb begin
        rise_nxt = sync_r & ~prev_r;
        fall_nxt = ~sync_r & prev_r;
    end

    // Two-stage synchroniser followed by a history stage and registered pulses.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
            rise_o <= rise_nxt;
            fall_o <= fall_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/mtm_pkg.sv ----
// Purpose: Shared constants for the 8-bit modulo timer.
// Assumes: AXI4-Lite register access with 32-bit data.
// Notes:   Offsets are byte addresses of aligned words.
package mtm_pkg;
    localparam logic [3:0] OFS_STATUS_CTRL = 4'h0;
    localparam logic [3:0] OFS_CLOCK_CFG   = 4'h4;
    localparam logic [3:0] OFS_COUNT       = 4'h8;
    localparam logic [3:0] OFS_WRAP        = 4'hc;
    localparam int BIT_OVF   = 7;
    localparam int BIT_OVIE  = 6;
    localparam int BIT_CLR   = 5;
    localparam int BIT_HALT  = 4;
    localparam int SRC_HI    = 5;
    localparam int SRC_LO    = 4;
    localparam int PS_HI     = 3;
    localparam int PS_LO     = 0;
    localparam logic [3:0] PS_MAX      = 4'h8;
    localparam logic [7:0] RST_COUNT   = 8'h00;
    localparam logic [7:0] RST_WRAP    = 8'h00;
    localparam logic [1:0] RST_SRC     = 2'h0;
    localparam logic [3:0] RST_PS      = 4'h0;
    localparam logic       RST_HALT    = 1'b1;
    localparam logic [1:0] SRC_BUS     = 2'h0;
    localparam logic [1:0] SRC_FIXED   = 2'h1;
    localparam logic [1:0] SRC_EXT_FALL = 2'h2;
    localparam logic [1:0] SRC_EXT_RISE = 2'h3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- rtl/mtm_prescaler.sv ----
// Purpose: Divides source ticks by a power of two from 1 to 256.
// Assumes: src_tick_i is a one-cycle enable pulse.
// Notes:   The divider keeps running across a change of setting.
`timescale 1ns/1ps
`default_nettype none
module mtm_prescaler (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic       src_tick_i,
    input  wire logic [3:0] ps_i,
    output logic            tick_o
);
    logic [7:0] div_r;
    logic [7:0] div_nxt;
    logic [7:0] mask;
    logic       tick_nxt;
    logic [3:0] ps_eff;

    // Codes above eight divide by 256; a tick fires when the low bits roll over.
    always_comb begin
        ps_eff   = (ps_i > mtm_pkg::PS_MAX) ? mtm_pkg::PS_MAX : ps_i;
        mask     = 8'(9'((9'h001 << ps_eff) - 9'h001));
        div_nxt  = src_tick_i ? 8'(div_r + 8'h01) : div_r;
        tick_nxt = src_tick_i && ((div_r & mask) == mask);
    end

    // Counter state is not cleared on a setting change, so the count is untouched.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            div_r  <= 8'h00;
            tick_o <= 1'b0;
        end else begin
            div_r  <= div_nxt;
            tick_o <= tick_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/mtm_timer.sv ----
// Purpose: 8-bit modulo timer with AXI4-Lite registers.
// Assumes: 40 MHz bus clock; external pin at most a quarter of that rate.
// Notes:   Overflow interrupt output is a plain registered level.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - External pin is synchronised to the bus clock and edge-detected before the prescaler.
// - Overflow flag bit 7 sets when count wraps from wrap value to zero.
// - Flag clears by status read while set, then writing zero to it.
// - Counter-clear write of one or any wrap write also clears the flag.
// - Interrupt asserts while flag and enable bit 6 are set; reset clears enable.
// - Writing one to bit 5 zeroes the count and flag; reads zero.
// - Halt bit 4 freezes the count; reset sets it.
// - Status bits 3:0 and clock config bits 7:6 read zero.
// - Source field 5:4 picks bus, fixed, external falling or rising edge.
// - Source or prescale change keeps the count running from its value.
// - Prescale field divides by two to the code, 256 above eight.
// - Reset clears source and prescale fields to bus clock divided by one.
// - Count register reads current count, ignores writes, resets to zero.
// - Wrap register is read/write; zero means free running; resets to zero.
// - Writing the wrap register forces the count to zero.
// - Count increments per prescaler tick until equal to wrap, then wraps.
// - An overflow between read and zero write keeps the flag set.
// - Debug suspend holds the count; counting resumes afterwards.
module mtm_timer (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        ext_timer_clock_in_i,
    input  wire logic        fixed_frequency_clock_tick_i,
    input  wire logic        debug_halt_i,
    output logic             irq_o,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // Registers and state.
    logic       overflow_flag_r, overflow_flag_nxt;
    logic       overflow_irq_enable_r, overflow_irq_enable_nxt;
    logic       counter_halt_r, counter_halt_nxt;
    logic [1:0] clock_source_select_r, clock_source_select_nxt;
    logic [3:0] prescale_select_r, prescale_select_nxt;
    logic [7:0] count_r, count_nxt;
    logic [7:0] wrap_value_r, wrap_value_nxt;
    logic       clear_armed_r, clear_armed_nxt;
    logic       dbg_meta_r, dbg_sync_r;
    // Bus state.
    logic       aw_held_r, aw_held_nxt;
    logic [3:0] aw_addr_r, aw_addr_nxt;
    logic       w_held_r, w_held_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic       bvalid_nxt, rvalid_nxt, irq_nxt;
    logic [1:0] bresp_nxt, rresp_nxt;
    logic [31:0] rdata_nxt;
    // Combinational helpers.
    logic       ext_rise, ext_fall, src_tick, pre_tick, count_tick, wrap_event;
    logic       wr_fire, rd_fire, wr_lane0;
    logic       wr_sc, wr_clk, wr_wrap, rd_sc;
    logic       wr_known, rd_known;
    logic [7:0] rd_byte;

    mtm_edge_sync u_edge (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .pin_i     (ext_timer_clock_in_i),
        .rise_o    (ext_rise),
        .fall_o    (ext_fall)
    );

    // Source selection feeding the prescaler as one-cycle enables.
    always_comb begin
        case (clock_source_select_r)
            mtm_pkg::SRC_BUS:      src_tick = 1'b1;
            mtm_pkg::SRC_FIXED:    src_tick = fixed_frequency_clock_tick_i;
            mtm_pkg::SRC_EXT_FALL: src_tick = ext_fall;
            mtm_pkg::SRC_EXT_RISE: src_tick = ext_rise;
            default:               src_tick = 1'b1;
        endcase
    end

    mtm_prescaler u_pre (
        .clk_sys_i  (clk_sys_i),
        .rst_n_i    (rst_n_i),
        .src_tick_i (src_tick),
        .ps_i       (prescale_select_r),
        .tick_o     (pre_tick)
    );

    // Bus handshake: address and data are accepted independently, then one response.
    always_comb begin
        aw_held_nxt = aw_held_r;
        aw_addr_nxt = aw_addr_r;
        w_held_nxt  = w_held_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
        if (wr_fire) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
        end
        rd_fire   = s_axi_arvalid && s_axi_arready;
        wr_lane0  = wr_fire && w_strb_r[0];
        wr_known  = (aw_addr_r[1:0] == 2'b00);
        rd_known  = (s_axi_araddr[1:0] == 2'b00);
        wr_sc     = wr_lane0 && wr_known && (aw_addr_r == mtm_pkg::OFS_STATUS_CTRL);
        wr_clk    = wr_lane0 && wr_known && (aw_addr_r == mtm_pkg::OFS_CLOCK_CFG);
        wr_wrap   = wr_lane0 && wr_known && (aw_addr_r == mtm_pkg::OFS_WRAP);
        rd_sc     = rd_fire && (s_axi_araddr == mtm_pkg::OFS_STATUS_CTRL);
        bvalid_nxt = wr_fire ? 1'b1 : (s_axi_bready ? 1'b0 : s_axi_bvalid);
        bresp_nxt  = wr_fire ? (wr_known ? mtm_pkg::RESP_OKAY : mtm_pkg::RESP_SLVERR)
                             : s_axi_bresp;
        // Read mux; unused high bits stay zero.
        case (s_axi_araddr)
            mtm_pkg::OFS_STATUS_CTRL: rd_byte = {overflow_flag_r, overflow_irq_enable_r,
                                                 1'b0, counter_halt_r, 4'h0};
            mtm_pkg::OFS_CLOCK_CFG:   rd_byte = {2'b00, clock_source_select_r,
                                                 prescale_select_r};
            mtm_pkg::OFS_COUNT:       rd_byte = count_r;
            mtm_pkg::OFS_WRAP:        rd_byte = wrap_value_r;
            default:                  rd_byte = 8'h00;
        endcase
        rvalid_nxt = rd_fire ? 1'b1 : (s_axi_rready ? 1'b0 : s_axi_rvalid);
        rdata_nxt  = rd_fire ? {24'h000000, rd_byte} : s_axi_rdata;
        rresp_nxt  = rd_fire ? (rd_known ? mtm_pkg::RESP_OKAY : mtm_pkg::RESP_SLVERR)
                             : s_axi_rresp;
    end

    // Counter, flag and control next-state.
    always_comb begin
        overflow_irq_enable_nxt = overflow_irq_enable_r;
        counter_halt_nxt        = counter_halt_r;
        clock_source_select_nxt = clock_source_select_r;
        prescale_select_nxt     = prescale_select_r;
        wrap_value_nxt          = wrap_value_r;
        count_nxt               = count_r;
        overflow_flag_nxt       = overflow_flag_r;
        clear_armed_nxt         = clear_armed_r;
        count_tick = pre_tick && !counter_halt_r && !dbg_sync_r;
        wrap_event = count_tick && (count_r == wrap_value_r) &&
                     (wrap_value_r != 8'h00);
        if (count_tick && wrap_value_r == 8'h00 && count_r == 8'hff) begin
            wrap_event = 1'b1;
        end
        if (count_tick) begin
            count_nxt = wrap_event ? 8'h00 : 8'(count_r + 8'h01);
        end
        if (rd_sc && overflow_flag_r) begin
            clear_armed_nxt = 1'b1;
        end
        if (wr_sc) begin
            overflow_irq_enable_nxt = w_data_r[mtm_pkg::BIT_OVIE];
            counter_halt_nxt        = w_data_r[mtm_pkg::BIT_HALT];
            if (!w_data_r[mtm_pkg::BIT_OVF] && clear_armed_r) begin
                overflow_flag_nxt = 1'b0;
            end
            if (w_data_r[mtm_pkg::BIT_CLR]) begin
                count_nxt         = 8'h00;
                overflow_flag_nxt = 1'b0;
            end
            clear_armed_nxt = 1'b0;
        end
        if (wr_clk) begin
            clock_source_select_nxt = w_data_r[mtm_pkg::SRC_HI:mtm_pkg::SRC_LO];
            prescale_select_nxt     = w_data_r[mtm_pkg::PS_HI:mtm_pkg::PS_LO];
        end
        if (wr_wrap) begin
            wrap_value_nxt    = w_data_r[7:0];
            count_nxt         = 8'h00;
            overflow_flag_nxt = 1'b0;
            clear_armed_nxt   = 1'b0;
        end
        // A fresh overflow wins over any clear and disarms the pending clear.
        if (wrap_event) begin
            overflow_flag_nxt = 1'b1;
            clear_armed_nxt   = 1'b0;
        end
        irq_nxt = overflow_flag_nxt && overflow_irq_enable_nxt;
    end

    // All state registers; reset holds the timer halted on bus clock.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            overflow_flag_r       <= 1'b0;
            overflow_irq_enable_r <= 1'b0;
            counter_halt_r        <= mtm_pkg::RST_HALT;
            clock_source_select_r <= mtm_pkg::RST_SRC;
            prescale_select_r     <= mtm_pkg::RST_PS;
            count_r               <= mtm_pkg::RST_COUNT;
            wrap_value_r          <= mtm_pkg::RST_WRAP;
            clear_armed_r         <= 1'b0;
            dbg_meta_r            <= 1'b0;
            dbg_sync_r            <= 1'b0;
            aw_held_r             <= 1'b0;
            aw_addr_r             <= 4'h0;
            w_held_r              <= 1'b0;
            w_data_r              <= 32'h00000000;
            w_strb_r              <= 4'h0;
            s_axi_bvalid          <= 1'b0;
            s_axi_bresp           <= 2'h0;
            s_axi_rvalid          <= 1'b0;
            s_axi_rdata           <= 32'h00000000;
            s_axi_rresp           <= 2'h0;
            s_axi_awready         <= 1'b1;
            s_axi_wready          <= 1'b1;
            s_axi_arready         <= 1'b1;
            irq_o                 <= 1'b0;
        end else begin
            overflow_flag_r       <= overflow_flag_nxt;
            overflow_irq_enable_r <= overflow_irq_enable_nxt;
            counter_halt_r        <= counter_halt_nxt;
            clock_source_select_r <= clock_source_select_nxt;
            prescale_select_r     <= prescale_select_nxt;
            count_r               <= count_nxt;
            wrap_value_r          <= wrap_value_nxt;
            clear_armed_r         <= clear_armed_nxt;
            dbg_meta_r            <= debug_halt_i;
            dbg_sync_r            <= dbg_meta_r;
            aw_held_r             <= aw_held_nxt;
            aw_addr_r             <= aw_addr_nxt;
            w_held_r              <= w_held_nxt;
            w_data_r              <= w_data_nxt;
            w_strb_r              <= w_strb_nxt;
            s_axi_bvalid          <= bvalid_nxt;
            s_axi_bresp           <= bresp_nxt;
            s_axi_rvalid          <= rvalid_nxt;
            s_axi_rdata           <= rdata_nxt;
            s_axi_rresp           <= rresp_nxt;
            s_axi_awready         <= !aw_held_nxt; // Registered, so the port is a flop.
            s_axi_wready          <= !w_held_nxt;
            s_axi_arready         <= !rvalid_nxt;
            irq_o                 <= irq_nxt;
        end
    end

    // Checks on timer behaviour; each label line carries the rule it guards.
    chk_wrap_sets_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wrap_event |=> overflow_flag_r && count_r == 8'h00) else $error("wrap lost");
    chk_irq_follows: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (overflow_flag_r && overflow_irq_enable_r) |-> irq_o) else $error("irq missing");
    chk_halt_holds: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (counter_halt_r && !wr_sc && !wr_wrap) |=> $stable(count_r)) else $error("halt moved");
    chk_wrap_write_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_wrap && !wrap_event |=> count_r == 8'h00 && !overflow_flag_r) else $error("wrap wr");
    chk_clr_no_arm: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (overflow_flag_r && !clear_armed_r && wr_sc && !w_data_r[mtm_pkg::BIT_CLR])
        |=> overflow_flag_r) else $error("flag cleared unarmed");
    chk_count_limit: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (wrap_value_r != 8'h00 && count_r <= wrap_value_r && !wr_wrap && !wr_clk)
        |=> count_r <= wrap_value_r) else $error("count past wrap");
    chk_rd_zero_bits: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000) else $error("high bits");
    chk_debug_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        dbg_sync_r && !wr_sc && !wr_wrap |=> $stable(count_r)) else $error("debug moved");
    chk_clr_zeroes: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_sc && w_data_r[mtm_pkg::BIT_CLR] && !wrap_event
        |=> count_r == 8'h00 && !overflow_flag_r) else $error("clear missed");
    chk_clear_seq: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_sc && clear_armed_r && !w_data_r[mtm_pkg::BIT_OVF] && !wrap_event
        |=> !overflow_flag_r) else $error("armed clear missed");
    chk_src_keeps: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_clk && !count_tick |=> $stable(count_r)) else $error("count moved on cfg");
    chk_count_ro: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_fire && aw_addr_r == mtm_pkg::OFS_COUNT && !count_tick
        |=> $stable(count_r)) else $error("count written");
    chk_bus_rate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $past(rst_n_i) && $past({clock_source_select_r, prescale_select_r}) == 6'h00
        |-> pre_tick) else $error("bus tick missing");
    // Covers for the main scenarios.
    cov_flag_kept: cover property (@(posedge clk_sys_i) clear_armed_r && wrap_event);
    cov_ext_tick: cover property (@(posedge clk_sys_i) count_tick && clock_source_select_r[1]);
    cov_wrap: cover property (@(posedge clk_sys_i) wrap_event);
    cov_irq: cover property (@(posedge clk_sys_i) irq_o);
    cov_clear_seq: cover property (@(posedge clk_sys_i) clear_armed_r ##[1:20] !overflow_flag_r);
endmodule
`default_nettype wire

// ---- sim/mtm_ext_src.sv ----
// Purpose: Model of the external clock source on the timer clock pin.
// Assumes: The bench starts each burst; the pin stands still low between bursts.
// Notes:   A half period of HALF_CYC bus cycles keeps the pin slow enough to sample.
`timescale 1ns/1ps
`default_nettype none
module mtm_ext_src #(
    parameter int HALF_CYC = 3
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic       start_i,
    input  wire logic [3:0] pulses_i,
    output logic            pin_o
);
    int phase;
    int halves;

    // Each burst makes whole pin cycles, rising first, and ends low.
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pin_o  <= 1'b0;
            halves <= 0;
            phase  <= 0;
        end else if (start_i) begin
            halves <= 2 * int'(pulses_i);
            phase  <= 0;
        end else if (halves > 0) begin
            if (phase == HALF_CYC - 1) begin
                pin_o  <= ~pin_o;
                halves <= halves - 1;
                phase  <= 0;
            end else begin
                phase <= phase + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- sim/mtm_timer_tb_top.sv ----
// Purpose: Self-checking bench for the 8-bit modulo timer.
// Assumes: Register access over AXI4-Lite; every answer is awaited under a bound.
// Notes:   Prescaled counts are judged in a window, as the divider phase runs free.
`timescale 1ns/1ps
`default_nettype none
module mtm_timer_tb_top;
    localparam logic [3:0] st = mtm_pkg::OFS_STATUS_CTRL;
    localparam logic [3:0] ck = mtm_pkg::OFS_CLOCK_CFG;
    localparam logic [3:0] cn = mtm_pkg::OFS_COUNT;
    localparam logic [3:0] wp = mtm_pkg::OFS_WRAP;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        fix_tick = 1'b0;
    logic        dbg = 1'b0;
    logic        pin;
    logic        src_go = 1'b0;
    logic        irq;
    logic [3:0]  awaddr = 4'h0;
    logic        awvalid = 1'b0;
    logic        awready;
    logic [31:0] wdata = 32'h0;
    logic        wvalid = 1'b0;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready = 1'b0;
    logic [3:0]  araddr = 4'h0;
    logic        arvalid = 1'b0;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready = 1'b0;
    logic [31:0] rv;
    logic [1:0]  rs;
    int          err_count = 0;
    int          checked = 0;

    mtm_timer dut_u (
        .clk_sys_i(clk),
        .rst_n_i(rst_n),
        .ext_timer_clock_in_i(pin),
        .fixed_frequency_clock_tick_i(fix_tick),
        .debug_halt_i(dbg),
        .irq_o(irq),
        .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid),
        .s_axi_awready(awready),
        .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid),
        .s_axi_wready(wready),
        .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid),
        .s_axi_bready(bready),
        .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid),
        .s_axi_arready(arready),
        .s_axi_rdata(rdata),
        .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid),
        .s_axi_rready(rready)
    );

    mtm_ext_src src_u (
        .clk_sys_i(clk),
        .rst_n_i(rst_n),
        .start_i(src_go),
        .pulses_i(4'h5),
        .pin_o(pin)
    );

    // Bus clock at 40 MHz.
    always #12.5 clk = ~clk;

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d.", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
        checked++;
        if (seen !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, seen);
        end
    endtask

    task automatic tmo();
        err_count++;
        $display("ERROR bus wait expected answer seen none");
        final_report();
    endtask

    // Both write channels are offered together and released one by one when taken.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) begin
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
            end
            if (n > 50) begin
                tmo();
            end
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a);
        int n;
        n = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
            if (n > 50) begin
                tmo();
            end
        end while (rvalid !== 1'b1);
        rv = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input string nm);
        rd(a);
        check(nm, rv, e);
    endtask

    // Every status read that finds the flag set also arms the clear sequence.
    task automatic poll_flag();
        int n;
        n = 0;
        do begin
            rd(st);
            n++;
            if (n > 200) begin
                tmo();
            end
        end while (rv[7] !== 1'b1);
    endtask

    // Main sequence of register-level scenarios.
    initial begin
        int          n;
        int          dv;
        logic [31:0] sv;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk(st, 32'h10, "status reset");
        rd_chk(ck, 32'h0, "clock cfg reset");
        rd_chk(cn, 32'h0, "count reset");
        rd_chk(wp, 32'h0, "wrap reset");
        rd(4'h1);
        check("unaligned resp", 32'(rs), 32'(mtm_pkg::RESP_SLVERR));
        wr(4'h6, 32'h0);
        check("unaligned write resp", 32'(rs), 32'(mtm_pkg::RESP_SLVERR));
        wr(wp, 32'h4);
        wr(st, 32'h0);
        repeat (40) @(posedge clk);
        check("irq masked", 32'(irq), 32'h0);
        wr(st, 32'h10);
        rd(cn);
        check("count within wrap", 32'(rv <= 32'h4), 32'h1);
        rd_chk(st, 32'h90, "flag after wrap");
        wr(wp, 32'h4);
        rd_chk(st, 32'h10, "flag after wrap write");
        rd_chk(cn, 32'h0, "count after wrap write");
        wr(cn, 32'h55);
        check("count write resp", 32'(rs), 32'(mtm_pkg::RESP_OKAY));
        rd_chk(cn, 32'h0, "count ignores write");
        wr(st, 32'h0);
        repeat (40) @(posedge clk);
        wr(st, 32'h3f);
        rd_chk(st, 32'h10, "status after counter clear");
        rd_chk(cn, 32'h0, "count after counter clear");
        wr(ck, 32'hff);
        rd_chk(ck, 32'h3f, "clock cfg unused bits");
        wr(ck, 32'h0);
        wr(st, 32'h40);
        n = 0;
        while (irq !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        check("irq raised", 32'(irq), 32'h1);
        wr(st, 32'h30);
        check("irq dropped", 32'(irq), 32'h0);
        // Free running: the flag clears only after a read, unless it overflows again.
        wr(wp, 32'h0);
        wr(st, 32'h0);
        poll_flag();
        wr(st, 32'h0);
        rd(st);
        check("flag cleared", 32'(rv[7]), 32'h0);
        poll_flag();
        repeat (300) @(posedge clk);
        wr(st, 32'h0);
        rd(st);
        check("flag kept", 32'(rv[7]), 32'h1);
        // Prescale codes zero to nine; code nine is the only code above eight tried.
        for (int i = 0; i < 10; i++) begin
            dv = (i > 8) ? 256 : (1 << i);
            wr(st, 32'h10);
            wr(ck, 32'(i));
            wr(wp, 32'h0);
            wr(st, 32'h0);
            repeat (32 * dv) @(posedge clk);
            wr(st, 32'h10);
            rd(cn);
            check("prescaled count", 32'(rv >= 31 && rv <= 33 + 12 / dv), 32'h1);
        end
        wr(st, 32'h0);
        repeat (600) @(posedge clk);
        wr(ck, {26'h0, mtm_pkg::SRC_FIXED, 4'h8});
        rd(cn);
        sv = rv;
        check("count kept on source change", 32'(sv >= 33), 32'h1);
        repeat (600) @(posedge clk);
        rd_chk(cn, sv, "fixed source idle");
        // Fixed ticks, then falling and rising pin edges, five of each.
        for (int i = 1; i < 4; i++) begin
            wr(st, 32'h10);
            wr(ck, {26'h0, 2'(i), 4'h0});
            wr(wp, 32'h0);
            wr(st, 32'h0);
            if (i == 1) begin
                repeat (5) begin
                    fix_tick <= 1'b1;
                    @(posedge clk);
                    fix_tick <= 1'b0;
                    @(posedge clk);
                end
            end else begin
                src_go <= 1'b1;
                @(posedge clk);
                src_go <= 1'b0;
                repeat (40) @(posedge clk);
            end
            repeat (8) @(posedge clk);
            wr(st, 32'h10);
            rd_chk(cn, 32'h5, "source edges counted");
        end
        // Debug suspend holds the count, release resumes it.
        wr(ck, 32'h0);
        wr(st, 32'h0);
        dbg <= 1'b1;
        repeat (4) @(posedge clk);
        rd(cn);
        sv = rv;
        repeat (20) @(posedge clk);
        rd_chk(cn, sv, "count in debug");
        dbg <= 1'b0;
        repeat (20) @(posedge clk);
        rd(cn);
        check("count resumes", 32'(rv > sv), 32'h1);
        final_report();
    end
endmodule
`default_nettype wire
